// file: scp_pkg.sv
/*
  constants and types shared by the serial command port of the uart.
  assumes one 50 MHz clock and a sampled serial link from a bus master.
*/
package scp_pkg;
  // ---------------------------------------------------------------
  // frame command codes, top two bits of each 16-bit frame
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_RD_DATA = 2'b00,
    OP_RD_CFG  = 2'b01,
    OP_WR_DATA = 2'b10,
    OP_WR_CFG  = 2'b11
  } scp_op_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } scp_tx_t;

  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_RUN  = 1'b1
  } scp_rx_t;

  // ---------------------------------------------------------------
  // field positions of the setup word and the data word
  // ---------------------------------------------------------------
  localparam int CFG_FIFO_DIS = 13;
  localparam int CFG_SHDN     = 12;
  localparam int CFG_MASK_HI  = 11;
  localparam int CFG_MASK_LO  = 8;
  localparam int CFG_IR       = 7;
  localparam int CFG_STOP2    = 6;
  localparam int CFG_PAR_EN   = 5;
  localparam int CFG_LEN7     = 4;
  localparam int CFG_BAUD_HI  = 3;
  localparam int DW_TX_DIS    = 10;
  localparam int DW_RTS       = 9;
  localparam int DW_PAR       = 8;
  localparam int MSK_TX       = 3;
  localparam int MSK_RX       = 2;
  localparam int MSK_PAR      = 1;
  localparam int MSK_ACT      = 0;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [13:0] CFG_RST     = 14'h0000;
  localparam logic [3:0]  MASK_RST    = 4'h0;
  localparam logic [4:0]  SYNC_RST    = 5'h19;
  localparam logic [4:0]  FRAME_LAST  = 5'h0f;
  localparam logic [4:0]  FRAME_BITS  = 5'h10;
  localparam logic [19:0] BAUD_UNIT   = 20'h00002;
  localparam logic [3:0]  OVS_MID     = 4'h7;
  localparam logic [3:0]  IR_TICKS    = 4'h3;
  localparam int          RXQ_DEPTH   = 8;
  localparam int          RXQ_WIDTH   = 9;
endpackage

// file: scp_top.sv
/*
  serial command port of a uart: frame decode, setup word, receive queue,
  a small transmitter and receiver, test mode.
  assumes a bus master driving chip select, serial clock and data in,
  with a serial clock far slower than MCLK_I.
*/

// -----------------------------------------------------------------
// receive queue
// -----------------------------------------------------------------
module scp_fifo
  import scp_pkg::*;
#(
  parameter int W = RXQ_WIDTH,
  parameter int D = RXQ_DEPTH
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  wire          full_w;
  wire          push_w;
  wire          pop_w;

  assign full_w      = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
  assign in_ready_o  = !full_w;
  assign out_valid_o = (wp_r != rp_r);
  assign out_data_o  = mem_r[rp_r[AW-1:0]];
  assign push_w      = in_valid_i && !full_w;
  assign pop_w       = out_ready_i && out_valid_o;

  always_ff @(posedge clk_i) begin
    if (push_w) begin
      mem_r[wp_r[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (flush_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push_w) wp_r <= wp_r + 1'b1;
      if (pop_w) rp_r <= rp_r + 1'b1;
    end
  end
endmodule

// -----------------------------------------------------------------
// top of the command port
// -----------------------------------------------------------------
module scp_top
  import scp_pkg::*;
(
  input  wire logic MCLK_I,
  input  wire logic RST_B_I,
  input  wire logic CS_B_I,
  input  wire logic SCLK_I,
  input  wire logic DIN_I,
  input  wire logic RX_I,
  input  wire logic CTS_B_I,
  output logic      DOUT_O,
  output logic      TX_O,
  output logic      RTS_B_O,
  output logic      IRQ_B_O
);
  function automatic logic [11:0] scp_frame(input logic [7:0] c, input logic p,
                                            input logic l7, input logic pe);
    logic [11:0] f;
    f      = 12'hfff;
    f[0]   = 1'b0;
    f[7:1] = c[6:0];
    if (l7) begin
      if (pe) f[8] = p;
    end else begin
      f[8] = c[7];
      if (pe) f[9] = p;
    end
    return f;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers, change counts when stages two and three agree
  // ---------------------------------------------------------------
  wire  [4:0] pin_w;
  logic [4:0] s1_r, s2_r, s3_r, lvl_r, lvl_d_r;
  wire  [4:0] lvl_nxt;
  assign pin_w   = {CTS_B_I, RX_I, DIN_I, SCLK_I, CS_B_I};
  assign lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s1_r    <= SYNC_RST;
      s2_r    <= SYNC_RST;
      s3_r    <= SYNC_RST;
      lvl_r   <= SYNC_RST;
      lvl_d_r <= SYNC_RST;
    end else begin
      s1_r    <= pin_w;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      lvl_r   <= lvl_nxt;
      lvl_d_r <= lvl_r;
    end
  end

  wire cs_low   = !lvl_r[0];
  wire cs_fall  = lvl_d_r[0] && !lvl_r[0];
  wire cs_rise  = !lvl_d_r[0] && lvl_r[0];
  wire sck_rise = cs_low && lvl_r[1] && !lvl_d_r[1];
  wire sck_fall = cs_low && !lvl_r[1] && lvl_d_r[1];
  wire din      = lvl_r[2];
  wire rx_lvl   = lvl_r[3];
  wire rx_edge  = lvl_r[3] ^ lvl_d_r[3];
  wire cts_b    = lvl_r[4];

  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  logic [4:0]  bitcnt_r, idx_r;
  logic [15:0] in_sr_r;
  logic [13:0] payload_r, pend_cfg_r, cfg_r;
  logic [1:0]  snap_rt_r;
  logic [10:0] dw_r;
  logic [3:0]  mask_r;
  logic        frame_ok_r, rd_taken_r, test_r, cfg_pend_r, rts_r, fe_r;
  scp_op_t     cmd_r;
  logic [8:0]  txbuf_r;
  logic        txbuf_full_r;
  scp_tx_t     tx_st_r;
  logic [11:0] tx_sr_r;
  logic [3:0]  tx_n_r, tx_sub_r;
  scp_rx_t     rx_st_r;
  logic [10:0] rx_sr_r;
  logic [3:0]  rx_n_r, rx_sub_r;
  logic        rx_vld_r;
  logic [8:0]  rx_word_r;
  logic [19:0] brg_r;

  // ---------------------------------------------------------------
  // receive queue and flags
  // ---------------------------------------------------------------
  wire        head_vld_w, q_ready_w, rx_take_w;
  wire [8:0]  head_w;
  wire        flush_w  = cs_rise && frame_ok_r && (cmd_r == OP_WR_CFG);
  wire        pop_w    = sck_fall && (bitcnt_r == FRAME_BITS) && rd_taken_r
                         && !cmd_r[0];
  wire        r_flag   = head_vld_w;
  wire        t_flag   = !txbuf_full_r;
  wire        shdn_w   = cfg_r[CFG_SHDN];
  wire        len7_w   = cfg_r[CFG_LEN7];
  wire        pe_w     = cfg_r[CFG_PAR_EN];
  assign      rx_take_w = rx_vld_r && (cfg_r[CFG_FIFO_DIS] ? !head_vld_w : q_ready_w);

  scp_fifo #(.W(RXQ_WIDTH), .D(RXQ_DEPTH)) u_rxq (
    .clk_i       (MCLK_I),
    .rst_b_i     (RST_B_I),
    .flush_i     (flush_w),
    .in_valid_i  (rx_take_w),
    .in_ready_o  (q_ready_w),
    .in_data_i   (rx_word_r),
    .out_valid_o (head_vld_w),
    .out_ready_i (pop_w),
    .out_data_o  (head_w)
  );

  // ---------------------------------------------------------------
  // frame shifter and command decode
  // ---------------------------------------------------------------
  wire [1:0]  op_early_w = {in_sr_r[0], din};
  wire [15:0] word_w     = {in_sr_r[14:0], din};
  wire [13:0] cfg_rb_w   = {cfg_r[13], shdn_w && tx_st_r == TX_IDLE, mask_r, cfg_r[7:0]};
  wire [13:0] dat_rb_w   = {3'h0, fe_r, !cts_b, head_vld_w ? head_w : 9'h000};
  wire [13:0] pay_sel_w  = (op_early_w == OP_RD_CFG) ? cfg_rb_w :
                           (op_early_w == OP_WR_CFG) ? 14'h0000 : dat_rb_w;
  wire        last_rise  = sck_rise && (bitcnt_r == FRAME_LAST);
  wire [15:0] out_word_w = {snap_rt_r, payload_r};
  wire        dout_nxt   = cs_low && out_word_w[4'(5'd15 - idx_r)];

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      bitcnt_r   <= '0;
      idx_r      <= '0;
      in_sr_r    <= '0;
      payload_r  <= '0;
      snap_rt_r  <= '0;
      frame_ok_r <= 1'b0;
      rd_taken_r <= 1'b0;
      cmd_r      <= OP_RD_DATA;
    end else if (cs_fall) begin
      bitcnt_r   <= '0;
      idx_r      <= '0;
      payload_r  <= '0;
      snap_rt_r  <= {r_flag, t_flag};
      frame_ok_r <= 1'b0;
      rd_taken_r <= 1'b0;
    end else begin
      if (sck_rise && bitcnt_r < FRAME_BITS) begin
        in_sr_r  <= word_w;
        bitcnt_r <= bitcnt_r + 5'h01;
      end
      if (sck_rise && bitcnt_r == 5'h01) begin
        payload_r  <= pay_sel_w;
        rd_taken_r <= head_vld_w;
      end
      if (last_rise) begin
        frame_ok_r <= 1'b1;
        cmd_r      <= scp_op_t'(word_w[15:14]);
      end
      if (sck_fall && idx_r < FRAME_LAST) idx_r <= idx_r + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // setup word, data write fields, test mode
  // ---------------------------------------------------------------
  wire tx_done_w = (tx_st_r == TX_IDLE) && !txbuf_full_r;
  wire dw_go_w   = cs_rise && frame_ok_r && (cmd_r == OP_WR_DATA);

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mask_r     <= MASK_RST;
      pend_cfg_r <= CFG_RST;
      cfg_r      <= CFG_RST;
      cfg_pend_r <= 1'b0;
      dw_r       <= '0;
      test_r     <= 1'b0;
      rts_r      <= 1'b0;
    end else begin
      if (last_rise && word_w[15:14] == OP_WR_CFG) begin
        mask_r     <= word_w[CFG_MASK_HI:CFG_MASK_LO];
        pend_cfg_r <= word_w[13:0];
      end
      if (last_rise && word_w[15:14] == OP_RD_CFG) test_r <= word_w[0];
      else if (cs_rise) test_r <= 1'b0;
      if (last_rise && word_w[15:14] == OP_WR_DATA) dw_r <= word_w[10:0];
      if (flush_w) cfg_pend_r <= 1'b1;
      else if (cfg_pend_r && tx_done_w) begin
        cfg_r      <= pend_cfg_r;
        cfg_pend_r <= 1'b0;
      end
      if (dw_go_w) rts_r <= dw_r[DW_RTS];
    end
  end

  // ---------------------------------------------------------------
  // baud generator, 16x tick, stops in shutdown once idle
  // ---------------------------------------------------------------
  wire [19:0] div_w    = 20'(BAUD_UNIT << cfg_r[CFG_BAUD_HI:0]);
  wire        run_w    = !(shdn_w && tx_st_r == TX_IDLE);
  wire        tick_w   = run_w && (brg_r == 20'h00000);
  wire        tclk_w   = brg_r >= (div_w >> 1);

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) brg_r <= '0;
    else if (!run_w) brg_r <= '0;
    else brg_r <= (brg_r == 20'h00000) ? div_w - 20'h00001 : brg_r - 20'h00001;
  end

  // ---------------------------------------------------------------
  // transmitter: holding buffer and shifter
  // ---------------------------------------------------------------
  wire [3:0] tx_len_w = 4'ha - {3'h0, cfg_r[CFG_LEN7]} + {3'h0, pe_w}
                        + {3'h0, cfg_r[CFG_STOP2]};

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      txbuf_r      <= '0;
      txbuf_full_r <= 1'b0;
      tx_st_r      <= TX_IDLE;
      tx_sr_r      <= 12'hfff;
      tx_n_r       <= '0;
      tx_sub_r     <= '0;
    end else begin
      if (dw_go_w && !dw_r[DW_TX_DIS] && !txbuf_full_r) begin
        txbuf_r      <= dw_r[8:0];
        txbuf_full_r <= 1'b1;
      end else if (flush_w) begin
        txbuf_full_r <= 1'b0;
      end else if (tx_st_r == TX_IDLE && txbuf_full_r && tick_w && !dw_go_w) begin
        txbuf_full_r <= 1'b0;
      end
      unique case (tx_st_r)
        TX_IDLE: begin
          if (txbuf_full_r && tick_w && !flush_w && !dw_go_w) begin
            tx_sr_r  <= scp_frame(txbuf_r[7:0], txbuf_r[DW_PAR], len7_w, pe_w);
            tx_n_r   <= tx_len_w;
            tx_sub_r <= '0;
            tx_st_r  <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tick_w) begin
            tx_sub_r <= tx_sub_r + 4'h1;
            if (tx_sub_r == 4'hf) begin
              tx_sr_r <= {1'b1, tx_sr_r[11:1]};
              tx_n_r  <= tx_n_r - 4'h1;
              if (tx_n_r == 4'h1) tx_st_r <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  wire tx_bit_w = (tx_st_r == TX_IDLE) || tx_sr_r[0];
  wire ir_out_w = (tx_st_r == TX_SEND) && !tx_sr_r[0] && (tx_sub_r < IR_TICKS);
  wire test_w   = test_r && cs_low;
  wire tx_nxt   = !test_w && (cfg_r[CFG_IR] ? ir_out_w : tx_bit_w);
  wire rts_nxt  = test_w ? tclk_w : !rts_r;

  // ---------------------------------------------------------------
  // receiver, sampled mid-bit at 16x
  // ---------------------------------------------------------------
  wire [3:0] rx_stop_w = 4'h9 - {3'h0, len7_w} + {3'h0, pe_w};
  wire [7:0] rx_char_w = len7_w ? {1'b0, rx_sr_r[7:1]} : rx_sr_r[8:1];
  wire       rx_par_w  = pe_w && (len7_w ? rx_sr_r[8] : rx_sr_r[9]);
  wire       rx_mid_w  = tick_w && rx_st_r == RX_RUN && rx_sub_r == OVS_MID;
  wire       rx_fe_w   = rx_mid_w && rx_n_r == rx_stop_w && !rx_lvl;
  wire       rx_ok_w   = rx_mid_w && rx_n_r == rx_stop_w && rx_lvl;

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rx_st_r   <= RX_IDLE;
      rx_sr_r   <= '0;
      rx_n_r    <= '0;
      rx_sub_r  <= '0;
      rx_vld_r  <= 1'b0;
      rx_word_r <= '0;
    end else begin
      if (rx_ok_w) begin
        rx_vld_r  <= 1'b1;
        rx_word_r <= {rx_par_w, rx_char_w};
      end else if (flush_w || rx_take_w) rx_vld_r <= 1'b0;
      unique case (rx_st_r)
        RX_IDLE: begin
          if (tick_w && !rx_lvl && !shdn_w) begin
            rx_st_r  <= RX_RUN;
            rx_sub_r <= 4'h1;
            rx_n_r   <= '0;
          end
        end
        RX_RUN: begin
          if (tick_w) rx_sub_r <= rx_sub_r + 4'h1;
          if (rx_mid_w) begin
            rx_sr_r[rx_n_r] <= rx_lvl;
            rx_n_r          <= rx_n_r + 4'h1;
            if ((rx_n_r == 4'h0 && rx_lvl) || rx_n_r == rx_stop_w) rx_st_r <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // activity or framing flag, set wins over clear
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) fe_r <= 1'b0;
    else if (rx_fe_w || (shdn_w && rx_edge)) fe_r <= 1'b1;
    else if (flush_w || rx_ok_w) fe_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // interrupt level and output flops
  // ---------------------------------------------------------------
  wire irq_nxt = !((mask_r[MSK_TX] && t_flag) || (mask_r[MSK_RX] && r_flag)
                   || (mask_r[MSK_PAR] && r_flag && head_w[8])
                   || (mask_r[MSK_ACT] && fe_r));

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      DOUT_O  <= 1'b0;
      TX_O    <= 1'b1;
      RTS_B_O <= 1'b1;
      IRQ_B_O <= 1'b1;
    end else begin
      DOUT_O  <= dout_nxt;
      TX_O    <= tx_nxt;
      RTS_B_O <= rts_nxt;
      IRQ_B_O <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);

  dout_msb_a: assert property (cs_fall |-> ##2 DOUT_O == snap_rt_r[1])
    else $error("msb not shown after select fall");
  mask_now_a: assert property (last_rise && word_w[15:14] == 2'b11
    |=> mask_r == $past(word_w[11:8]))
    else $error("masks not applied at 16th rise");
  wcfg_zero_a: assert property (sck_rise && bitcnt_r == 5'h01 && op_early_w == 2'b11
    |=> payload_r == 14'h0000)
    else $error("setup write payload not zero");
  rcfg_back_a: assert property (sck_rise && bitcnt_r == 5'h01 && op_early_w == 2'b01
    |=> payload_r == $past(cfg_rb_w))
    else $error("read-back differs from setup");
  test_tx_a: assert property (test_r && cs_low |=> !TX_O)
    else $error("tx not low in test mode");
  test_end_a: assert property (cs_rise |=> !test_r)
    else $error("test mode kept after select rise");
  cfg_defer_a: assert property (cfg_pend_r && !tx_done_w && !flush_w
    |=> cfg_r == $past(cfg_r))
    else $error("setup applied during transmission");
  flush_q_a: assert property (flush_w |=> ##1 !head_vld_w)
    else $error("queue not flushed by setup write");
  txdis_a: assert property (dw_go_w && dw_r[DW_TX_DIS]
    |=> txbuf_full_r == $past(txbuf_full_r) && rts_r == $past(dw_r[DW_RTS]))
    else $error("disabled write touched transmitter");
  pop_edge_a: assert property (pop_w |-> sck_fall && bitcnt_r == 5'h10)
    else $error("pop outside 16th falling edge");
endmodule

// file: scp_spi_master.sv
/*
  bus master model for the serial command port: frames 16-bit words,
  msb first, serial clock idle low, 160 ns period.
  assumes clk_i is the 50 MHz system clock of the port.
*/
module scp_spi_master (
  input  wire logic   clk_i,
  input  wire logic   dout_i,
  output logic        cs_b_o,
  output logic        sclk_o,
  output logic        din_o,
  output logic [15:0] word_o,
  output logic        done_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    din_o  = 1'b0;
    word_o = 16'h0000;
    done_o = 1'b0;
  end

  // -----------------------------------------------------------------
  // one frame; hold keeps select low after the last pulse
  // -----------------------------------------------------------------
  task automatic xfer(input logic [15:0] w, input int hold);
    logic [15:0] r;
    @(posedge clk_i);
    cs_b_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 15; i >= 0; i--) begin
      din_o <= w[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      r[i] = dout_i;
      sclk_o <= 1'b0;
    end
    repeat (4 + hold) @(posedge clk_i);
    cs_b_o <= 1'b1;
    word_o <= r;
    done_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
    din_o  <= ~din_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// file: testbench.sv
/*
  self-checking bench of the serial command port: frames through the
  master model, transmit looped back to receive.
  assumes scp_top and scp_spi_master are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic              mclk;
  logic              rst_b;
  logic              cts_b;
  logic              c;
  logic              rts_s;
  wire logic         cs_b;
  wire logic         sclk;
  wire logic         din;
  wire logic         dout;
  wire logic         tx;
  wire logic         rts_b;
  wire logic         irq_b;
  wire logic         done;
  wire logic [15:0]  word;
  int                errors;
  int                n_checks;
  int                cycles;
  int                seed;
  logic [31:0]       exp_q[$];
  logic [7:0]        ch[$];
  logic [31:0]       e;

  scp_top DUT (.MCLK_I(mclk), .RST_B_I(rst_b), .CS_B_I(cs_b), .SCLK_I(sclk), .DIN_I(din),
    .RX_I(tx), .CTS_B_I(cts_b), .DOUT_O(dout), .TX_O(tx), .RTS_B_O(rts_b), .IRQ_B_O(irq_b));
  scp_spi_master M (.clk_i(mclk), .dout_i(dout), .cs_b_o(cs_b), .sclk_o(sclk), .din_o(din),
    .word_o(word), .done_o(done));

  task automatic check(input logic [15:0] got, input logic [15:0] want);
    n_checks++;
    if (got !== want) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  task automatic note(input logic [15:0] m, input logic [15:0] v);
    exp_q.push_back({m, v});
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // -----------------------------------------------------------------
  // returned words against the oldest note; hang guard
  // -----------------------------------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 12000) begin
      errors++;
      end_sim();
    end else if (done) begin
      e = exp_q.pop_front();
      check(word & e[31:16], e[15:0]);
    end
  end

  initial begin
    rst_b = 1'b0;
    cts_b = 1'b0;
    seed = 74877;
    errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    // setup: rx-available mask only, 8 bits, no parity, divisor 0
    note(16'hffff, 16'h4000);
    M.xfer(16'hc400, 0);
    note(16'hffff, 16'h4400);
    M.xfer(16'h4000, 0);
    check({15'h0, irq_b}, 16'h0001);
    // each write returns the previous character and pops it
    for (int i = 0; i < 4; i++) begin
      c = $random(seed);
      cts_b <= c;
      ch.push_back($random(seed));
      note(16'hfeff, {i > 0, 1'b1, 4'h0, ~c, 1'b0, (i > 0) ? ch[i-1] : 8'h00});
      M.xfer({8'h80, ch[i]}, 0);
      repeat (400) @(posedge mclk);
    end
    check({15'h0, irq_b}, 16'h0000);
    note(16'hfcff, {8'hc0, ch[3]});
    M.xfer(16'h0000, 0);
    note(16'h8000, 16'h0000);
    M.xfer(16'h0000, 0);
    check({15'h0, irq_b}, 16'h0001);
    // transmit disabled: only the request line moves
    note(16'hc000, 16'h4000);
    M.xfer(16'h86a5, 0);
    repeat (8) @(posedge mclk);
    check({15'h0, rts_b}, 16'h0000);
    repeat (60) @(posedge mclk);
    check({15'h0, tx}, 16'h0001);
    note(16'h8000, 16'h0000);
    M.xfer(16'h0000, 0);
    // test mode with select held low after the frame
    fork
      begin
        note(16'hffff, 16'h4400);
        M.xfer(16'h4001, 40);
      end
      begin
        repeat (150) @(posedge mclk);
        check({15'h0, tx}, 16'h0000);
        rts_s = rts_b;
        @(posedge mclk);
        check({15'h0, rts_b}, {15'h0, ~rts_s});
      end
    join
    repeat (20) @(posedge mclk);
    check({15'h0, tx}, 16'h0001);
    repeat (400) @(posedge mclk);
    // parity, seven bits, two stops, divisor 1; stale looped word masked
    note(16'h7fff, 16'h4000);
    M.xfer(16'hc071, 0);
    note(16'hffff, 16'h4071);
    M.xfer(16'h4000, 0);
    note(16'hfdff, 16'h4000);
    M.xfer(16'h81da, 0);
    repeat (800) @(posedge mclk);
    note(16'hfdff, 16'hc15a);
    M.xfer(16'h0000, 0);
    end_sim();
  end
endmodule
